// [design/crf_core_regs.sv]
// Core architectural state: data registers, program counter, flags, return stack
`timescale 1ns/1ps
// Functional notes
// (RL1) 8-bit accumulator, also read/write in data space at ffh.
// (RL2) Indirect pointers live in data space at 80h and 81h.
// (RL3) Short-direct registers live in data space at 82h and 83h.
// (RL4) Program counter is 12 bits, reaching 4096 program bytes.
// (RL5) Counter advances after fetch; ordinary step adds one.
// (RL6) Jump/call load target, interrupt/reset load vector, returns load popped value.
// (RL7) Relative branch adds signed offset to counter.
// (RL8) Three carry/zero pairs, one per context; only active pair used.
// (RL9) Entering irq or nmi switches pair; irq exit restores previous.
// (RL10) Pairs keep their values across switches, each reached only in context.
// (RL11) Carry follows arithmetic carry/borrow and takes part in rotate-left.
// (RL12) Bit test copies tested bit into active carry.
// (RL13) Zero set when last arithmetic/logic result is zero, else cleared.
// (RL14) Reset enters nmi context, nmi pair active.
// (RL15) Six-level 12-bit return stack, no visible pointer.
// (RL16) Push shifts levels deeper, counter to first, sixth lost.
// (RL17) Return pops first level to counter, others shift up.
// (RL18) Over-deep nesting keeps stack full, earliest address lost.
// (RL19) Return on empty stack keeps stack, continues sequentially.
// (RL20) Call pushes the incremented counter so return resumes after call.
module crf_core_regs #(
    parameter logic [11:0] RESET_PC = crf_pkg::PC_RESET
) (
    input wire logic i_ref_clk,                       // 100 MHz core clock
    input wire logic i_rstn,                          // Async reset, low
    input crf_pkg::crf_ds_req_t i_ds,                 // Data-space access
    input crf_pkg::crf_pc_op_t i_pc_op,               // Counter update source
    input wire logic [crf_pkg::PC_W-1:0] i_target,    // Jump/call target or vector
    input wire logic [crf_pkg::DATA_W-1:0] i_rel_off, // Signed branch offset
    input crf_pkg::crf_alu_t i_alu,                   // ALU result and flags
    output logic [crf_pkg::DATA_W-1:0] o_ds_rdata,    // Read data
    output logic o_ds_hit,                            // Read hit a mapped register
    output logic [crf_pkg::DATA_W-1:0] o_sum_reg,     // Accumulator
    output logic [crf_pkg::DATA_W-1:0] o_ptr_one,     // First pointer
    output logic [crf_pkg::DATA_W-1:0] o_ptr_two,     // Second pointer
    output logic [crf_pkg::DATA_W-1:0] o_short_one,   // First short-direct reg
    output logic [crf_pkg::DATA_W-1:0] o_short_second,// Second short-direct reg
    output logic [crf_pkg::PC_W-1:0] o_instr_pointer, // Program counter
    output crf_pkg::crf_ctx_t o_ctx,                  // Active context
    output logic o_carry,                             // Active carry
    output logic o_zero                               // Active zero
);
    // ------------------------------------------------------------
    // Data-space registers
    // ------------------------------------------------------------
    logic [7:0] sum_reg;
    logic [7:0] ptr_one;
    logic [7:0] ptr_two;
    logic [7:0] short_one;
    logic [7:0] short_second;
    logic [7:0] next_sum_reg;
    logic [7:0] next_ptr_one;
    logic [7:0] next_ptr_two;
    logic [7:0] next_short_one;
    logic [7:0] next_short_second;
    logic [7:0] ds_rdata;
    logic [7:0] next_ds_rdata;
    logic ds_hit;
    logic next_ds_hit;
    always_comb begin
        next_sum_reg = sum_reg;
        next_ptr_one = ptr_one;
        next_ptr_two = ptr_two;
        next_short_one = short_one;
        next_short_second = short_second;
        next_ds_rdata = 8'h00;
        next_ds_hit = 1'b0;
        if (i_ds.wr) begin
            unique case (i_ds.addr)
                crf_pkg::ADDR_SUM_REG: next_sum_reg = i_ds.wdata; // [RL1]
                crf_pkg::ADDR_PTR_ONE: next_ptr_one = i_ds.wdata; // [RL2]
                crf_pkg::ADDR_PTR_TWO: next_ptr_two = i_ds.wdata; // [RL2]
                crf_pkg::ADDR_SHORT_ONE: next_short_one = i_ds.wdata; // [RL3]
                crf_pkg::ADDR_SHORT_SECOND: next_short_second = i_ds.wdata; // [RL3]
                default: next_sum_reg = sum_reg;
            endcase
        end
        if (i_ds.rd) begin
            next_ds_hit = 1'b1;
            unique case (i_ds.addr)
                crf_pkg::ADDR_SUM_REG: next_ds_rdata = sum_reg; // [RL1]
                crf_pkg::ADDR_PTR_ONE: next_ds_rdata = ptr_one; // [RL2]
                crf_pkg::ADDR_PTR_TWO: next_ds_rdata = ptr_two;
                crf_pkg::ADDR_SHORT_ONE: next_ds_rdata = short_one; // [RL3]
                crf_pkg::ADDR_SHORT_SECOND: next_ds_rdata = short_second;
                default: next_ds_hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sum_reg <= crf_pkg::REG_RESET;
            ptr_one <= crf_pkg::REG_RESET;
            ptr_two <= crf_pkg::REG_RESET;
            short_one <= crf_pkg::REG_RESET;
            short_second <= crf_pkg::REG_RESET;
            ds_rdata <= crf_pkg::REG_RESET;
            ds_hit <= 1'b0;
        end else begin
            sum_reg <= next_sum_reg;
            ptr_one <= next_ptr_one;
            ptr_two <= next_ptr_two;
            short_one <= next_short_one;
            short_second <= next_short_second;
            ds_rdata <= next_ds_rdata;
            ds_hit <= next_ds_hit;
        end
    end

    // ------------------------------------------------------------
    // Program counter and return stack
    // ------------------------------------------------------------
    logic [11:0] instr_pointer;
    logic [11:0] next_instr_pointer;
    logic push;
    logic pop;
    logic [11:0] push_val;
    logic [11:0] stack_top;
    logic stack_empty;
    logic [11:0] rel_ext;
    assign rel_ext = {{4{i_rel_off[7]}}, i_rel_off};
    always_comb begin
        next_instr_pointer = instr_pointer;
        push = 1'b0;
        pop = 1'b0;
        push_val = instr_pointer;
        unique case (i_pc_op)
            crf_pkg::PC_HOLD: next_instr_pointer = instr_pointer;
            crf_pkg::PC_INC: next_instr_pointer = instr_pointer + crf_pkg::PC_ONE; // [RL5]
            crf_pkg::PC_JUMP: next_instr_pointer = i_target; // [RL6]
            crf_pkg::PC_CALL: begin
                next_instr_pointer = i_target; // [RL6]
                push = 1'b1;
                push_val = instr_pointer + crf_pkg::PC_ONE; // [RL20]
            end
            crf_pkg::PC_REL: next_instr_pointer = instr_pointer + rel_ext; // [RL7]
            crf_pkg::PC_IRQ, crf_pkg::PC_NMI: begin
                next_instr_pointer = i_target; // [RL6]
                push = 1'b1; // [RL16]
            end
            crf_pkg::PC_SUB_EXIT, crf_pkg::PC_IRQ_EXIT: begin
                pop = 1'b1; // [RL17]
                // Empty stack: fall through to the next instruction
                next_instr_pointer = stack_empty ? instr_pointer + crf_pkg::PC_ONE : stack_top; // [RL19]
            end
            default: next_instr_pointer = instr_pointer;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            instr_pointer <= RESET_PC; // [RL6]
        end else begin
            instr_pointer <= next_instr_pointer; // [RL4]
        end
    end

    crf_stack #(
        .DEPTH(crf_pkg::STACK_DEPTH)
    ) u_stack (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_push(push),
        .i_pop(pop),
        .i_push_val(push_val), // [RL15]
        .o_top(stack_top),
        .o_empty(stack_empty),
        .o_depth()
    );

    // ------------------------------------------------------------
    // Context and flags
    // ------------------------------------------------------------
    crf_pkg::crf_ctx_t ctx;
    crf_pkg::crf_ctx_t next_ctx;
    crf_pkg::crf_ctx_t ctx_before_nmi;
    crf_pkg::crf_ctx_t next_ctx_before_nmi;
    logic carry_we;
    logic carry_val;
    logic zero_we;
    logic carry_next;
    logic zero_next;
    logic carry_q;
    logic zero_q;
    // One saved context suffices: only nmi can nest over irq
    always_comb begin
        next_ctx = ctx;
        next_ctx_before_nmi = ctx_before_nmi;
        unique case (i_pc_op)
            crf_pkg::PC_IRQ: next_ctx = crf_pkg::CTX_IRQ; // [RL9]
            crf_pkg::PC_NMI: begin
                next_ctx = crf_pkg::CTX_NMI; // [RL9]
                next_ctx_before_nmi = ctx;
            end
            crf_pkg::PC_IRQ_EXIT: begin
                next_ctx = (ctx == crf_pkg::CTX_NMI) ? ctx_before_nmi : crf_pkg::CTX_MAIN; // [RL9]
            end
            default: next_ctx = ctx;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctx <= crf_pkg::CTX_NMI; // [RL14]
            ctx_before_nmi <= crf_pkg::CTX_MAIN;
        end else begin
            ctx <= next_ctx;
            ctx_before_nmi <= next_ctx_before_nmi;
        end
    end

    always_comb begin
        carry_we = 1'b0;
        carry_val = i_alu.carry;
        zero_we = 1'b0;
        if (i_alu.valid) begin
            unique case (i_alu.kind)
                crf_pkg::ALU_ARITH: begin
                    carry_we = 1'b1; // [RL11]
                    zero_we = 1'b1; // [RL13]
                end
                crf_pkg::ALU_LOGIC: zero_we = 1'b1; // [RL13]
                crf_pkg::ALU_BIT_TEST: begin
                    carry_we = 1'b1;
                    carry_val = i_alu.bit_value; // [RL12]
                end
                crf_pkg::ALU_ROTL: carry_we = 1'b1; // [RL11]
                default: carry_we = 1'b0;
            endcase
        end
    end

    // Updates hit the current pair; outputs follow the pair active after the edge
    crf_flags u_flags (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_ctx(ctx), // [RL8]
        .i_ctx_next(next_ctx), // [RL9]
        .i_carry_we(carry_we),
        .i_carry_val(carry_val),
        .i_zero_we(zero_we),
        .i_zero_val(i_alu.result == 8'h00),
        .o_carry_next(carry_next),
        .o_zero_next(zero_next)
    );
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            carry_q <= 1'b0;
            zero_q <= 1'b0;
        end else begin
            carry_q <= carry_next;
            zero_q <= zero_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_ds_rdata = ds_rdata;
    assign o_ds_hit = ds_hit;
    assign o_sum_reg = sum_reg;
    assign o_ptr_one = ptr_one;
    assign o_ptr_two = ptr_two;
    assign o_short_one = short_one;
    assign o_short_second = short_second;
    assign o_instr_pointer = instr_pointer;
    assign o_ctx = ctx;
    assign o_carry = carry_q;
    assign o_zero = zero_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic after_rst;
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            after_rst <= 1'b1;
        end else begin
            after_rst <= 1'b0;
        end
    end
    property p_acc_write;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_ds.wr && i_ds.addr == crf_pkg::ADDR_SUM_REG) ##1 (i_ds.rd && i_ds.addr == crf_pkg::ADDR_SUM_REG)
            |=> o_ds_hit && (o_ds_rdata == $past(i_ds.wdata, 2));
    endproperty
    a_acc_write: assert property (p_acc_write) else $error("Accumulator readback mismatch"); // [RL1]
    property p_ptr_write;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_ds.wr && i_ds.addr == crf_pkg::ADDR_PTR_TWO) |=> (o_ptr_two == $past(i_ds.wdata)) && $stable(o_ptr_one);
    endproperty
    a_ptr_write: assert property (p_ptr_write) else $error("Pointer write wrong"); // [RL2]
    property p_short_write;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_ds.wr && i_ds.addr == crf_pkg::ADDR_SHORT_SECOND) |=> (o_short_second == $past(i_ds.wdata));
    endproperty
    a_short_write: assert property (p_short_write) else $error("Short-direct write wrong"); // [RL3]
    property p_pc_inc;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_pc_op == crf_pkg::PC_INC) |=> (o_instr_pointer == $past(o_instr_pointer) + crf_pkg::PC_ONE);
    endproperty
    a_pc_inc: assert property (p_pc_inc) else $error("Counter did not step by one"); // [RL5]
    property p_call_ret;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_pc_op == crf_pkg::PC_CALL) ##1 (i_pc_op == crf_pkg::PC_SUB_EXIT)
            |=> (o_instr_pointer == $past(o_instr_pointer, 2) + crf_pkg::PC_ONE);
    endproperty
    a_call_ret: assert property (p_call_ret) else $error("Return did not resume after call"); // [RL20]
    property p_rel;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_pc_op == crf_pkg::PC_REL) |=> (o_instr_pointer == $past(o_instr_pointer) + $past(rel_ext));
    endproperty
    a_rel: assert property (p_rel) else $error("Relative branch sum wrong"); // [RL7]
    property p_reset_nmi;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        after_rst |-> (o_ctx == crf_pkg::CTX_NMI) && (o_instr_pointer == RESET_PC);
    endproperty
    a_reset_nmi: assert property (p_reset_nmi) else $error("Not in nmi context after reset"); // [RL14]
    property p_zero;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_alu.valid && i_alu.kind == crf_pkg::ALU_LOGIC && next_ctx == ctx) |=> (o_zero == ($past(i_alu.result) == 8'h00));
    endproperty
    a_zero: assert property (p_zero) else $error("Zero flag wrong"); // [RL13]
    property p_bit_test;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_alu.valid && i_alu.kind == crf_pkg::ALU_BIT_TEST && next_ctx == ctx) |=> (o_carry == $past(i_alu.bit_value));
    endproperty
    a_bit_test: assert property (p_bit_test) else $error("Bit test carry wrong"); // [RL12]
    property p_irq_ctx;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_pc_op == crf_pkg::PC_IRQ && o_ctx == crf_pkg::CTX_MAIN) ##1 (i_pc_op == crf_pkg::PC_IRQ_EXIT)
            |=> (o_ctx == crf_pkg::CTX_MAIN);
    endproperty
    a_irq_ctx: assert property (p_irq_ctx) else $error("Irq exit did not restore context"); // [RL9]
endmodule

// [design/crf_pkg.sv]
// Package: shared constants and types for the core register/flag/stack block
package crf_pkg;
    // --------------------------------------------------------------
    // Widths and sizes
    // --------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int PC_W = 12;
    localparam int STACK_DEPTH = 6;
    localparam int DEPTH_W = 3;

    // --------------------------------------------------------------
    // Data-space addresses
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_PTR_ONE = 8'h80;
    localparam logic [7:0] ADDR_PTR_TWO = 8'h81;
    localparam logic [7:0] ADDR_SHORT_ONE = 8'h82;
    localparam logic [7:0] ADDR_SHORT_SECOND = 8'h83;
    localparam logic [7:0] ADDR_SUM_REG = 8'hff;

    // --------------------------------------------------------------
    // Reset values, counter step and depth limit
    // --------------------------------------------------------------
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [11:0] PC_RESET = 12'hffe;
    localparam logic [11:0] PC_ONE = 12'h001;
    localparam logic [11:0] STACK_RESET = 12'h000;
    localparam logic [2:0] DEPTH_MAX = 3'h6;

    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef enum logic [3:0] {
        PC_HOLD, PC_INC, PC_JUMP, PC_CALL, PC_REL, PC_IRQ, PC_NMI, PC_SUB_EXIT, PC_IRQ_EXIT
    } crf_pc_op_t;

    typedef enum logic [1:0] {
        ALU_ARITH, ALU_LOGIC, ALU_BIT_TEST, ALU_ROTL
    } crf_alu_kind_t;

    typedef enum logic [1:0] {
        CTX_MAIN, CTX_IRQ, CTX_NMI
    } crf_ctx_t;

    typedef struct packed {
        logic valid;
        crf_alu_kind_t kind;
        logic [7:0] result;
        logic carry;
        logic bit_value;
    } crf_alu_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } crf_ds_req_t;
endpackage

// [design/crf_stack.sv]
// Six-level hardware return stack with saturating depth
`timescale 1ns/1ps
module crf_stack #(
    parameter int DEPTH = crf_pkg::STACK_DEPTH
) (
    input wire logic i_ref_clk,                       // Core clock
    input wire logic i_rstn,                          // Async reset, low
    input wire logic i_push,                          // Push request
    input wire logic i_pop,                           // Pop request
    input wire logic [crf_pkg::PC_W-1:0] i_push_val,  // Value to push
    output logic [crf_pkg::PC_W-1:0] o_top,           // First level
    output logic o_empty,                             // No saved entry
    output logic [crf_pkg::DEPTH_W-1:0] o_depth       // Entries held
);
    logic [crf_pkg::PC_W-1:0] level [DEPTH];
    logic [crf_pkg::PC_W-1:0] next_level [DEPTH];
    logic [crf_pkg::DEPTH_W-1:0] depth;
    logic [crf_pkg::DEPTH_W-1:0] next_depth;

    // ------------------------------------------------------------
    // Level shifting
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_lvl
            always_comb begin
                next_level[g] = level[g];
                if (i_push) begin
                    next_level[g] = (g == 0) ? i_push_val : level[(g == 0) ? 0 : g - 1]; // [RL16]
                end else if (i_pop && depth != '0) begin
                    next_level[g] = (g == DEPTH - 1) ? crf_pkg::STACK_RESET
                                                     : level[(g == DEPTH - 1) ? g : g + 1]; // [RL17]
                end
            end
            always_ff @(posedge i_ref_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    level[g] <= crf_pkg::STACK_RESET;
                end else begin
                    level[g] <= next_level[g];
                end
            end
        end
    endgenerate

    // Oldest entry falls off; depth saturates
    always_comb begin
        next_depth = depth;
        if (i_push && depth != crf_pkg::DEPTH_MAX) begin
            next_depth = depth + 3'h1; // [RL18]
        end else if (i_pop && !i_push && depth != '0) begin
            next_depth = depth - 3'h1; // [RL19]
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            depth <= '0;
        end else begin
            depth <= next_depth;
        end
    end

    assign o_top = level[0];
    assign o_empty = (depth == '0);
    assign o_depth = depth;

    property p_stack_full;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_push && depth == crf_pkg::DEPTH_MAX) |=> (depth == crf_pkg::DEPTH_MAX) && (level[0] == $past(i_push_val));
    endproperty
    a_stack_full: assert property (p_stack_full) else $error("Stack depth left saturation"); // [RL18]

    property p_stack_empty_pop;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_pop && !i_push && depth == '0) |=> (depth == '0);
    endproperty
    a_stack_empty_pop: assert property (p_stack_empty_pop) else $error("Empty pop moved stack"); // [RL19]
endmodule

// [design/crf_flags.sv]
// Three context-banked carry/zero flag pairs
`timescale 1ns/1ps
module crf_flags (
    input wire logic i_ref_clk,          // Core clock
    input wire logic i_rstn,             // Async reset, low
    input crf_pkg::crf_ctx_t i_ctx,      // Active context
    input crf_pkg::crf_ctx_t i_ctx_next, // Context after this edge
    input wire logic i_carry_we,         // Update carry
    input wire logic i_carry_val,        // New carry
    input wire logic i_zero_we,          // Update zero
    input wire logic i_zero_val,         // New zero
    output logic o_carry_next,           // Next carry of active pair
    output logic o_zero_next             // Next zero of active pair
);
    logic [2:0] carry;
    logic [2:0] zero;
    logic [2:0] next_carry;
    logic [2:0] next_zero;

    // ------------------------------------------------------------
    // One pair per context, only the active one written
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pair
            always_comb begin
                next_carry[g] = carry[g];
                next_zero[g] = zero[g];
                if (int'(i_ctx) == g) begin // [RL8]
                    if (i_carry_we) begin
                        next_carry[g] = i_carry_val;
                    end
                    if (i_zero_we) begin
                        next_zero[g] = i_zero_val;
                    end
                end
            end
        end
    endgenerate

    // No clear on context change, pairs simply retained
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            carry <= 3'h0;
            zero <= 3'h0;
        end else begin
            carry <= next_carry; // [RL10]
            zero <= next_zero;
        end
    end

    // Read through the next context so a switch shows the new pair at once
    assign o_carry_next = next_carry[i_ctx_next]; // [RL9]
    assign o_zero_next = next_zero[i_ctx_next];

    property p_pair_kept;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_ctx != crf_pkg::CTX_MAIN) |=> (carry[0] == $past(carry[0])) && (zero[0] == $past(zero[0]));
    endproperty
    a_pair_kept: assert property (p_pair_kept) else $error("Main flags changed outside main"); // [RL10]
endmodule

// [test/crf_ds_master.sv]
// Data-space bus master standing in for the sequencer
`timescale 1ns/1ps
module crf_ds_master (
    input wire logic i_ref_clk,     // Core clock
    output crf_pkg::crf_ds_req_t o_ds // Access request
);
    initial o_ds = '0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        o_ds = {w, !w, a, d};
        @(negedge i_ref_clk);
        // Released lines flip so stale values never look valid
        o_ds = {2'b00, ~a, ~d};
    endtask
    // Write then read the same address on back-to-back edges
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        o_ds = {2'b10, a, d};
        @(negedge i_ref_clk);
        o_ds = {2'b01, a, ~d};
        @(negedge i_ref_clk);
        o_ds = {2'b00, ~a, ~d};
    endtask
endmodule

// [test/tb_crf_core_regs.sv]
// Self-checking bench for the core register, flag and stack block
`timescale 1ns/1ps
module tb_crf_core_regs;
    logic clk = 0, rstn = 0;
    crf_pkg::crf_ds_req_t ds;
    crf_pkg::crf_pc_op_t pc_op = crf_pkg::PC_HOLD;
    logic [11:0] tgt = '0, pc;
    logic [7:0] off = '0, rdata, sreg, p1, p2, s1, s2, exp[5];
    crf_pkg::crf_alu_t alu = '0;
    crf_pkg::crf_ctx_t ctx;
    logic hit, cy, zr;
    logic [15:0] seed = 16'hb846;
    logic [7:0] adr[5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
    int miscompares = 0, total_checks = 0;
    always #5 clk = ~clk;
    crf_ds_master i_crf_ds_master (.i_ref_clk(clk), .o_ds(ds));
    crf_core_regs i_crf_core_regs (.i_ref_clk(clk), .i_rstn(rstn), .i_ds(ds), .i_pc_op(pc_op), .i_target(tgt),
        .i_rel_off(off), .i_alu(alu), .o_ds_rdata(rdata), .o_ds_hit(hit), .o_sum_reg(sreg), .o_ptr_one(p1),
        .o_ptr_two(p2), .o_short_one(s1), .o_short_second(s2), .o_instr_pointer(pc), .o_ctx(ctx),
        .o_carry(cy), .o_zero(zr));
    function automatic logic [7:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed[7:0];
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        total_checks++;
        if (got !== want) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic op(input crf_pkg::crf_pc_op_t o, input logic [11:0] t);
        @(negedge clk);
        pc_op = o;
        tgt = t;
        @(negedge clk);
        pc_op = crf_pkg::PC_HOLD;
    endtask
    task automatic op2(input crf_pkg::crf_pc_op_t o, input logic [11:0] t, input crf_pkg::crf_pc_op_t o2);
        @(negedge clk);
        pc_op = o;
        tgt = t;
        @(negedge clk);
        pc_op = o2;
        @(negedge clk);
        pc_op = crf_pkg::PC_HOLD;
    endtask
    task automatic flg(input crf_pkg::crf_alu_kind_t k, input logic [7:0] r, input logic c, input logic b);
        @(negedge clk);
        alu = '{1'b1, k, r, c, b};
        @(negedge clk);
        alu = '0;
    endtask
    task automatic results();
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        results();
    end
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk) rstn = 1;
        chk(pc, 12'hffe);
        chk(ctx, crf_pkg::CTX_NMI);
        for (int i = 0; i < 5; i++) begin
            exp[i] = rnd();
            i_crf_ds_master.xfer(1'b1, adr[i], exp[i]);
        end
        chk({p1, p2}, {exp[0], exp[1]});
        chk({s1, s2}, {exp[2], exp[3]});
        chk(sreg, exp[4]);
        for (int i = 0; i < 5; i++) begin
            i_crf_ds_master.xfer(1'b0, adr[i], 8'h00);
            chk({hit, rdata}, {1'b1, exp[i]});
        end
        i_crf_ds_master.xfer(1'b0, 8'h84, 8'h00);
        chk({hit, rdata}, 9'h000);
        exp[4] = rnd();
        i_crf_ds_master.wr_rd(8'hff, exp[4]);
        chk({hit, rdata}, {1'b1, exp[4]});
        flg(crf_pkg::ALU_ARITH, 8'h00, 1'b1, 1'b0);
        chk({cy, zr}, 2'b11);
        op(crf_pkg::PC_IRQ_EXIT, 12'h000);
        chk({ctx, cy, zr}, {crf_pkg::CTX_MAIN, 2'b00});
        flg(crf_pkg::ALU_LOGIC, rnd() | 8'h01, 1'b1, 1'b0);
        flg(crf_pkg::ALU_ROTL, 8'h00, 1'b1, 1'b0);
        chk({cy, zr}, 2'b10);
        op(crf_pkg::PC_IRQ, 12'hff0);
        chk({ctx, cy, zr}, {crf_pkg::CTX_IRQ, 2'b00});
        flg(crf_pkg::ALU_BIT_TEST, 8'h00, 1'b0, 1'b1);
        chk(cy, 1'b1);
        op(crf_pkg::PC_NMI, 12'hffc);
        chk({ctx, cy, zr}, {crf_pkg::CTX_NMI, 2'b11});
        op(crf_pkg::PC_IRQ_EXIT, 12'h000);
        chk({ctx, cy, zr}, {crf_pkg::CTX_IRQ, 2'b10});
        op(crf_pkg::PC_IRQ_EXIT, 12'h000);
        chk({ctx, cy, zr}, {crf_pkg::CTX_MAIN, 2'b10});
        op2(crf_pkg::PC_IRQ, 12'hff0, crf_pkg::PC_IRQ_EXIT);
        chk({ctx, cy, zr}, {crf_pkg::CTX_MAIN, 2'b10});
        op(crf_pkg::PC_JUMP, 12'h100);
        chk(pc, 12'h100);
        op2(crf_pkg::PC_CALL, 12'h300, crf_pkg::PC_SUB_EXIT);
        chk(pc, 12'h101);
        // Seven nested calls: the first return address must fall off
        for (int k = 0; k < 7; k++) begin
            op(crf_pkg::PC_CALL, 12'h200 + 12'(k));
            chk(pc, 12'h200 + 12'(k));
        end
        for (int k = 6; k >= 1; k--) begin
            op(crf_pkg::PC_SUB_EXIT, 12'h000);
            chk(pc, 12'h200 + 12'(k));
        end
        op(crf_pkg::PC_SUB_EXIT, 12'h000);
        chk(pc, 12'h202);
        off = 8'hfc;
        op(crf_pkg::PC_REL, 12'h000);
        chk(pc, 12'h1fe);
        op(crf_pkg::PC_INC, 12'h000);
        chk(pc, 12'h1ff);
        results();
    end
endmodule
